// >>> verilog/ria_pkg.sv
// Purpose: shared types and constants for the reset, interrupt and acknowledge sequencer
// Assumes: one system clock at 50 MHz; phase clock one is derived by division
// Notes:   wait-state fields are three bits wide

package ria_pkg;

  localparam int unsigned SYS_PERIOD_NS = 20;
  localparam int unsigned PH1_PERIOD_NS = 40;
  localparam int unsigned PH1_CYCLES    = PH1_PERIOD_NS / SYS_PERIOD_NS;
  localparam int unsigned PH_CNT_W      = 1;
  localparam logic [PH_CNT_W-1:0] PH_LAST = PH_CNT_W'(PH1_CYCLES - 1);
  localparam logic [PH_CNT_W-1:0] PH_RISE = 1'h0;

  localparam int unsigned NUM_IRQ = 4;
  localparam int unsigned WAIT_W  = 3;

  localparam logic [WAIT_W-1:0] WAIT_RESET = 3'h7;
  localparam logic [WAIT_W-1:0] WAIT_MPU   = 3'h7;
  localparam logic [WAIT_W-1:0] WAIT_MCU   = 3'h0;

  localparam logic [NUM_IRQ-1:0] IRQ_IDLE_N = 4'hf;
  localparam logic [1:0]         SYNC_RST   = 2'h0;
  localparam logic [1:0]         SYNC_DONE  = 2'h3;

  // gray coded along hold -> fetch -> fetch -> run
  typedef enum logic [1:0] {
    ST_HOLD   = 2'h0,
    ST_FETCH1 = 2'h1,
    ST_FETCH2 = 2'h3,
    ST_RUN    = 2'h2
  } ria_state_e;

  // one bit per pin that is released during reset
  typedef struct packed {
    logic [1:0] external_flag_pins;
    logic       ser_tx_clock;
    logic       ser_tx_data;
    logic       ser_tx_frame;
    logic       ser_rx_clock;
    logic       ser_rx_data;
    logic       ser_rx_frame;
    logic [1:0] timer_clock_pins;
  } ria_pins_s;

  localparam ria_pins_s PINS_ALL_OFF = 10'h3ff;

endpackage

// >>> verilog/ria_sequencer.sv
// Purpose: reset entry sequence, external interrupt detection, acknowledge strobe
// Assumes: all inputs synchronous to CLK_SYS except NRST and EXT_IRQ_LINES_N
// Notes:   phase clock one is an enable pair, rise and fall, from a divider
//
// Overview of operation
// - reset floats flags, serial and timer pins
// - asynchronous reset; one extra cycle allowed
// - processor mode: two vector fetches, seven waits
// - computer mode: two vector fetches, zero waits
// - read/write direction outputs float during reset
// - interrupt lines are level sensitive, asynchronous
// - sample lines at phase one falling edge
// - interrupts consumed only at fetch boundaries
// - same line accepted every two phase cycles
// - late setup may detect one cycle later
// - strobe low at decode stage phase rise
// - strobe high at read stage phase rise
// - strobe low exactly one phase cycle (two clocks), always
// - reset loads bus controls with seven waits

`timescale 1ns/1ps
`default_nettype none

module ria_sequencer (
  input  wire logic                            CLK_SYS,
  input  wire logic                            NRST,
  input  wire logic                            MCU_MODE,
  input  wire logic [ria_pkg::NUM_IRQ-1:0]     EXT_IRQ_LINES_N,
  input  wire logic                            FETCH_BOUNDARY,
  input  wire logic [ria_pkg::NUM_IRQ-1:0]     IRQ_TAKE,
  input  wire logic                            FETCH_DONE,
  input  wire logic                            ACK_DECODE,
  input  wire ria_pkg::ria_pins_s              PIN_DRIVE_REQ,
  output logic [ria_pkg::NUM_IRQ-1:0]          IRQ_PENDING,
  output logic [ria_pkg::NUM_IRQ-1:0]          IRQ_DETECT,
  output logic                                 VEC_FETCH,
  output logic [ria_pkg::WAIT_W-1:0]           VEC_WAIT,
  output logic [ria_pkg::WAIT_W-1:0]           PRI_BUS_WAIT,
  output logic [ria_pkg::WAIT_W-1:0]           EXP_BUS_WAIT,
  output logic                                 CORE_RUN,
  output logic                                 IRQ_ACK_STROBE_N,
  output logic                                 RW_OE_N,
  output ria_pkg::ria_pins_s                   PIN_OE_N
);

  function automatic logic is_fetch(input ria_pkg::ria_state_e s);
    is_fetch = (s == ria_pkg::ST_FETCH1) || (s == ria_pkg::ST_FETCH2);
  endfunction

  // reset release path; assertion stays asynchronous
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rst_sync_q <= ria_pkg::SYNC_RST;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // phase clock one divider
  logic [ria_pkg::PH_CNT_W-1:0] ph_q;
  logic [ria_pkg::PH_CNT_W-1:0] ph_d;
  logic                         ph1_rise;
  logic                         ph1_fall;

  always_comb begin
    ph_d = (ph_q == ria_pkg::PH_LAST) ? '0 : ph_q + 1'b1;
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ph_q <= '0;
    end else begin
      ph_q <= ph_d;
    end
  end

  assign ph1_rise = (ph_q == ria_pkg::PH_RISE);
  assign ph1_fall = (ph_q == ria_pkg::PH_LAST);

  // interrupt detection
  logic [ria_pkg::NUM_IRQ-1:0] sync1_q, sync2_q;
  logic [ria_pkg::NUM_IRQ-1:0] lock_q, lock_d;
  logic [ria_pkg::NUM_IRQ-1:0] pend_q, pend_d;
  logic [ria_pkg::NUM_IRQ-1:0] det_q, det_d;
  logic [ria_pkg::NUM_IRQ-1:0] take;

  always_comb begin
    // level seen at the falling edge, not a transition
    det_d  = ph1_fall ? (~sync2_q & ~lock_q) : '0;
    // the line blocked for one phase cycle so a two-edge pulse counts once
    lock_d = ph1_fall ? det_d : lock_q;
    take   = FETCH_BOUNDARY ? IRQ_TAKE : '0;
    // a new detection wins over a consume in the same cycle
    pend_d = (pend_q & ~take) | det_d;
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= ria_pkg::IRQ_IDLE_N;
      sync2_q <= ria_pkg::IRQ_IDLE_N;
      lock_q  <= '0;
      pend_q  <= '0;
      det_q   <= '0;
    end else begin
      // two stage synchroniser; a missed setup costs one cycle
      sync1_q <= EXT_IRQ_LINES_N;
      sync2_q <= sync1_q;
      lock_q  <= lock_d;
      pend_q  <= pend_d;
      det_q   <= det_d;
    end
  end

  assign IRQ_PENDING = pend_q;
  assign IRQ_DETECT  = det_q;

  // reset vector fetch sequencer
  ria_pkg::ria_state_e st_q, st_d;
  logic                      mode_q, mode_d;
  logic [ria_pkg::WAIT_W-1:0] vwait_q, vwait_d;
  logic                      fetch_q;
  logic                      run_q;
  logic [ria_pkg::WAIT_W-1:0] pri_wait_q, pri_wait_d;
  logic [ria_pkg::WAIT_W-1:0] exp_wait_q, exp_wait_d;

  always_comb begin
    st_d   = st_q;
    mode_d = mode_q;
    case (st_q)
      ria_pkg::ST_HOLD: begin
        // strap caught by the clock while leaving reset
        mode_d = MCU_MODE;
        // start aligned to phase one; may add a cycle
        if (ph1_fall) begin
          st_d = ria_pkg::ST_FETCH1;
        end
      end
      ria_pkg::ST_FETCH1: begin
        if (FETCH_DONE) begin
          st_d = ria_pkg::ST_FETCH2;
        end
      end
      ria_pkg::ST_FETCH2: begin
        if (FETCH_DONE) begin
          st_d = ria_pkg::ST_RUN;
        end
      end
      ria_pkg::ST_RUN: begin
        st_d = ria_pkg::ST_RUN;
      end
      default: begin
        st_d = ria_pkg::ST_HOLD;
      end
    endcase
    vwait_d = mode_d ? ria_pkg::WAIT_MCU : ria_pkg::WAIT_MPU;
    // held at the slow reset value; no software path reaches them in this block
    pri_wait_d = pri_wait_q;
    exp_wait_d = exp_wait_q;
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= ria_pkg::ST_HOLD;
      mode_q  <= 1'b0;
      vwait_q <= ria_pkg::WAIT_MPU;
      fetch_q <= 1'b0;
      run_q   <= 1'b0;
      pri_wait_q <= ria_pkg::WAIT_RESET;
      exp_wait_q <= ria_pkg::WAIT_RESET;
    end else begin
      st_q    <= st_d;
      mode_q  <= mode_d;
      vwait_q <= vwait_d;
      fetch_q <= is_fetch(st_d);
      run_q   <= (st_d == ria_pkg::ST_RUN);
      pri_wait_q <= pri_wait_d;
      exp_wait_q <= exp_wait_d;
    end
  end

  assign VEC_FETCH = fetch_q;
  assign VEC_WAIT  = vwait_q;
  assign CORE_RUN  = run_q;
  // bus controls start slow; software reprograms them elsewhere
  assign PRI_BUS_WAIT = pri_wait_q;
  assign EXP_BUS_WAIT = exp_wait_q;

  // acknowledge strobe and pin release
  logic               ack_n_q, ack_n_d;
  logic               busy_q, busy_d;
  logic               start;
  logic               rw_oe_n_q, rw_oe_n_d;
  ria_pkg::ria_pins_s oe_n_q, oe_n_d;

  always_comb begin
    // a strobe still low is released first; no new one starts in that cycle
    start   = ph1_rise && ACK_DECODE && !busy_q && run_q && ack_n_q;
    ack_n_d = ack_n_q;
    if (!ack_n_q && ph1_rise) begin
      // release at the next rise even if decode is stretched
      ack_n_d = 1'b1;
    end else if (start) begin
      ack_n_d = 1'b0;
    end
    // busy blocks a second strobe for the same decode stage
    busy_d    = ACK_DECODE && (busy_q || start);
    rw_oe_n_d = (st_d == ria_pkg::ST_HOLD);
    oe_n_d    = (st_d == ria_pkg::ST_HOLD) ? ria_pkg::PINS_ALL_OFF : ~PIN_DRIVE_REQ;
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ack_n_q   <= 1'b1;
      busy_q    <= 1'b0;
      rw_oe_n_q <= 1'b1;
      oe_n_q    <= ria_pkg::PINS_ALL_OFF;
    end else begin
      ack_n_q   <= ack_n_d;
      busy_q    <= busy_d;
      rw_oe_n_q <= rw_oe_n_d;
      oe_n_q    <= oe_n_d;
    end
  end

  assign IRQ_ACK_STROBE_N = ack_n_q;
  assign RW_OE_N          = rw_oe_n_q;
  assign PIN_OE_N         = oe_n_q;

  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!rst_n);

  property p_pins_float;
    (st_q == ria_pkg::ST_HOLD) |-> (PIN_OE_N == ria_pkg::PINS_ALL_OFF);
  endproperty
  a_pins_float: assert property (p_pins_float) else $error("pins driven in reset");

  property p_rw_float;
    (st_q == ria_pkg::ST_HOLD) |-> RW_OE_N;
  endproperty
  a_rw_float: assert property (p_rw_float) else $error("rw driven in reset");

  property p_mpu_wait;
    (VEC_FETCH && !mode_q) |-> (VEC_WAIT == ria_pkg::WAIT_MPU);
  endproperty
  a_mpu_wait: assert property (p_mpu_wait) else $error("mpu fetch wait wrong");

  property p_mcu_wait;
    (VEC_FETCH && mode_q) |-> (VEC_WAIT == ria_pkg::WAIT_MCU);
  endproperty
  a_mcu_wait: assert property (p_mcu_wait) else $error("mcu fetch wait wrong");

  property p_two_fetch;
    (st_q == ria_pkg::ST_FETCH1 && FETCH_DONE) |=> (st_q == ria_pkg::ST_FETCH2) && VEC_FETCH;
  endproperty
  a_two_fetch: assert property (p_two_fetch) else $error("second fetch skipped");

  property p_detect_at_fall;
    (|IRQ_DETECT) |-> $past(ph1_fall);
  endproperty
  a_detect_at_fall: assert property (p_detect_at_fall) else $error("detect off edge");

  property p_consume_at_boundary;
    (|($past(pend_q) & ~pend_q)) |-> $past(FETCH_BOUNDARY);
  endproperty
  a_consume_at_boundary: assert property (p_consume_at_boundary) else $error("consumed mid op");

  property p_rate;
    (|det_q) |-> ((det_q & $past(det_q, 2)) == '0);
  endproperty
  a_rate: assert property (p_rate) else $error("line detected twice");

  property p_set_wins;
    (|det_d) |=> ((pend_q & $past(det_d)) == $past(det_d));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("detection lost");

  property p_ack_low;
    start |=> !IRQ_ACK_STROBE_N;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("strobe not low");

  property p_ack_release;
    (!IRQ_ACK_STROBE_N && ph1_rise) |=> IRQ_ACK_STROBE_N;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("strobe not released");

  property p_ack_width;
    $fell(IRQ_ACK_STROBE_N) |=> !IRQ_ACK_STROBE_N ##1 IRQ_ACK_STROBE_N [*2];
  endproperty
  a_ack_width: assert property (p_ack_width) else $error("strobe width wrong");

  property p_bus_wait;
    (st_q == ria_pkg::ST_HOLD) |-> (PRI_BUS_WAIT == ria_pkg::WAIT_RESET);
  endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("bus wait not seven");

  c_run: cover property ($rose(CORE_RUN));
  c_mcu: cover property (VEC_FETCH && mode_q);
  c_irq: cover property ((|IRQ_DETECT) ##[1:20] (FETCH_BOUNDARY && |(IRQ_TAKE & pend_q)));
  c_ack: cover property ($fell(IRQ_ACK_STROBE_N) ##2 ACK_DECODE);
  c_set_wins: cover property (|(det_d & take));

endmodule

`default_nettype wire

// >>> verification/ria_irq_src.sv
// Purpose: model of the external interrupt sources that drive the sequencer
// Assumes: lines are active low with pull-ups, so a released line reads high
// Notes:   pulse length is given in system clocks; callers start just after a rising edge

`timescale 1ns/1ps
`default_nettype none

module ria_irq_src (
  input  wire logic                            clk,
  output var  logic [ria_pkg::NUM_IRQ-1:0]     lines_n
);
  initial lines_n = ria_pkg::IRQ_IDLE_N;

  // level held for n clocks, then released to the pull-up level
  task automatic pulse(input logic [ria_pkg::NUM_IRQ-1:0] which, input int n);
    lines_n = ~which;
    repeat (n) @(posedge clk);
    #2 lines_n = ria_pkg::IRQ_IDLE_N;
  endtask
endmodule

`default_nettype wire

// >>> verification/tb_reset_irq_ack_sequencer.sv
// Purpose: self-checking bench for the reset, interrupt and acknowledge sequencer
// Assumes: inputs change 2 ns after the rising edge; outputs sampled 1 ns after it
// Notes:   detections and strobe widths are queued by the drivers and checked by a monitor

`timescale 1ns/1ps
`default_nettype none

module tb_reset_irq_ack_sequencer;
  logic                            CLK_SYS = 1'b0;
  logic                            NRST, MCU_MODE, FETCH_BOUNDARY, FETCH_DONE, ACK_DECODE;
  logic [ria_pkg::NUM_IRQ-1:0]     EXT_IRQ_LINES_N, IRQ_TAKE, IRQ_PENDING, IRQ_DETECT;
  logic                            VEC_FETCH, CORE_RUN, IRQ_ACK_STROBE_N, RW_OE_N;
  logic [ria_pkg::WAIT_W-1:0]      VEC_WAIT, PRI_BUS_WAIT, EXP_BUS_WAIT;
  ria_pkg::ria_pins_s              PIN_DRIVE_REQ, PIN_OE_N;
  int                              n_errors, n_tests, seed, low_run, m, i;
  logic [3:0]                      exp_q[$];
  int                              ack_q[$];
  logic [3:0]                      e, ln;
  int                              lens[3] = '{2, 3, 8};
  int                              dets[3] = '{1, 1, 2};

  always #10 CLK_SYS = ~CLK_SYS;

  ria_irq_src src (.clk(CLK_SYS), .lines_n(EXT_IRQ_LINES_N));

  ria_sequencer dut (
    .CLK_SYS(CLK_SYS), .NRST(NRST), .MCU_MODE(MCU_MODE), .EXT_IRQ_LINES_N(EXT_IRQ_LINES_N),
    .FETCH_BOUNDARY(FETCH_BOUNDARY), .IRQ_TAKE(IRQ_TAKE), .FETCH_DONE(FETCH_DONE),
    .ACK_DECODE(ACK_DECODE), .PIN_DRIVE_REQ(PIN_DRIVE_REQ), .IRQ_PENDING(IRQ_PENDING),
    .IRQ_DETECT(IRQ_DETECT), .VEC_FETCH(VEC_FETCH), .VEC_WAIT(VEC_WAIT),
    .PRI_BUS_WAIT(PRI_BUS_WAIT), .EXP_BUS_WAIT(EXP_BUS_WAIT), .CORE_RUN(CORE_RUN),
    .IRQ_ACK_STROBE_N(IRQ_ACK_STROBE_N), .RW_OE_N(RW_OE_N), .PIN_OE_N(PIN_OE_N)
  );

  task automatic err(input string msg);
    n_errors++;
    $display("[ERR] %0t %s", $time, msg);
  endtask

  task automatic results;
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // monitor: every detection pulse and every strobe run is matched against the oldest note
  always @(posedge CLK_SYS) begin
    #1;
    if (IRQ_DETECT !== 4'h0) begin
      n_tests++;
      if (exp_q.size() == 0) err("unexpected detection");
      else begin
        e = exp_q.pop_front();
        if (IRQ_DETECT !== e || (IRQ_PENDING & e) !== e) err("detection mismatch");
      end
    end
    if (IRQ_ACK_STROBE_N === 1'b0) low_run++;
    else if (low_run != 0) begin
      n_tests++;
      if (ack_q.size() == 0 || low_run != ack_q.pop_front()) err("strobe width");
      low_run = 0;
    end
  end

  // reset drops between edges to show it acts without a clock
  task automatic do_reset(input logic mode);
    NRST = 1'b0;
    MCU_MODE = mode;
    #3;
    n_tests++;
    if (PIN_OE_N !== ria_pkg::PINS_ALL_OFF || RW_OE_N !== 1'b1) err("pins driven in reset");
    repeat (12) @(posedge CLK_SYS);
    #2;
    n_tests++;
    if (PRI_BUS_WAIT !== 3'h7 || EXP_BUS_WAIT !== 3'h7 || CORE_RUN !== 1'b0) err("reset values");
    NRST = 1'b1;
  endtask

  task automatic boot(input logic mode);
    int k;
    do_reset(mode);
    k = 0;
    while (VEC_FETCH !== 1'b1 && k < 20) begin
      @(posedge CLK_SYS);
      #2;
      k++;
    end
    n_tests++;
    if (PIN_OE_N !== ~PIN_DRIVE_REQ || RW_OE_N !== 1'b0) err("pins after reset");
    // done stays high across both fetches so it is never lowered and raised in one step
    FETCH_DONE = 1'b1;
    repeat (2) begin
      n_tests++;
      if (VEC_FETCH !== 1'b1 || CORE_RUN !== 1'b0 || VEC_WAIT !== (mode ? 3'h0 : 3'h7)) err("vector fetch");
      @(posedge CLK_SYS);
      #2;
    end
    FETCH_DONE = 1'b0;
    @(posedge CLK_SYS);
    #2;
    n_tests++;
    if (CORE_RUN !== 1'b1 || VEC_FETCH !== 1'b0) err("sequence end");
  endtask

  task automatic irq(input logic [3:0] which, input int n, input int det);
    repeat (det) exp_q.push_back(which);
    src.pulse(which, n);
    repeat (8) @(posedge CLK_SYS);
    #2;
    n_tests++;
    if (exp_q.size() != 0 || IRQ_PENDING !== which) err("pending flags");
    IRQ_TAKE = which;
    @(posedge CLK_SYS);
    #2;
    n_tests++;
    if (IRQ_PENDING !== which) err("taken off boundary");
    FETCH_BOUNDARY = 1'b1;
    @(posedge CLK_SYS);
    #2;
    FETCH_BOUNDARY = 1'b0;
    IRQ_TAKE = 4'h0;
    n_tests++;
    if (IRQ_PENDING !== 4'h0) err("not consumed");
  endtask

  // consume held at the boundary while the line fires: the detection must still show for a cycle
  task automatic clash(input logic [3:0] which);
    @(posedge CLK_SYS);
    #2;
    exp_q.push_back(which);
    FETCH_BOUNDARY = 1'b1;
    IRQ_TAKE = which;
    src.pulse(which, 2);
    repeat (8) @(posedge CLK_SYS);
    #2;
    n_tests++;
    if (exp_q.size() != 0 || IRQ_PENDING !== 4'h0) err("set against consume");
    FETCH_BOUNDARY = 1'b0;
    IRQ_TAKE = 4'h0;
  endtask

  // decode held n clocks; the strobe must still be one phase cycle wide
  task automatic ack(input int n);
    ack_q.push_back(2);
    ACK_DECODE = 1'b1;
    repeat (n) @(posedge CLK_SYS);
    #2 ACK_DECODE = 1'b0;
    repeat (4) @(posedge CLK_SYS);
    #2;
    n_tests++;
    if (ack_q.size() != 0) err("no strobe");
  endtask

  initial begin
    seed = 401;
    n_errors = 0;
    n_tests = 0;
    low_run = 0;
    NRST = 1'b0;
    MCU_MODE = 1'b0;
    FETCH_BOUNDARY = 1'b0;
    FETCH_DONE = 1'b0;
    ACK_DECODE = 1'b0;
    IRQ_TAKE = 4'h0;
    PIN_DRIVE_REQ = 10'($random(seed));
    @(posedge CLK_SYS);
    #2;
    for (m = 0; m < 2; m++) begin
      PIN_DRIVE_REQ = 10'($random(seed));
      boot(m[0]);
      for (i = 0; i < 3; i++) begin
        ln = 4'($random(seed));
        if (ln == 4'h0) ln = 4'h8;
        irq(ln, lens[i], dets[i]);
      end
      ln = 4'($random(seed));
      if (ln == 4'h0) ln = 4'h1;
      clash(ln);
      ack(2);
      ack(5);
    end
    results;
  end

  // whole run is under two hundred clocks; this is over ten times that
  initial begin
    #40000;
    err("timeout");
    results;
  end
endmodule

`default_nettype wire
